// *** dac_two_wire_write_slave.sv ***
/*
  Receive-only two-wire slave of a 10-bit DAC: address decode, acknowledge,
  command and data input registers, STOP and SYNC driven output update.
  Assumes SDA and SCL come from an open-drain bus with pull-ups and that
  clk_in runs many times faster than SCL.
*/
`timescale 1ns/1ps
`include "dac_link_defines.svh"

// What this block does
// - Transactions open with START, seen as SDA falling while SCL high.
// - Transactions close with STOP, seen as SDA rising while SCL high.
// - Receive only; SDA is driven solely for acknowledges.
// - Accepted bytes are acknowledged by holding SDA low through ninth pulse.
// - Each data bit is sampled on the rising SCL edge.
// - Write address, then command byte; both acknowledged, command latched.
// - Low then high data byte follow, each acknowledged and latched.
// - STOP with stop update selected copies input to output registers.
// - Strapped variant address is four fixed upper bits plus three pins.
// - Pinless variant uses one of two fixed addresses.
// - Command bit0 sync select, bit1 power down, bit2 reference; rest ignored.
// - Sync select 1 updates only on SYNC command; 0 updates at STOP.
// - SYNC update happens on rising SCL of the SYNC acknowledge.
// - Power down select applies at next STOP, data kept, output floats.
// - Reference select 0 means supply, 1 means internal bandgap.
// - Code is high byte bits 1..0 above the whole low byte.
// - Repeated STARTs chain devices; the final STOP updates all together.
// - Send byte loads only the command, leaving data registers intact.
// - START or STOP between command ack and last data ack drops data.
// - START or STOP before the command ack drops the command.
// - The shared SYNC address is also answered as a quick command.
// - SYNC flag 1 updates if sync selected; flag 0 clears all latches.
module dac_two_wire_write_slave
  import dac_link_pkg::*;
#(
  parameter bit PINLESS = 1'b0,
  parameter logic [3:0] ADDR_UPPER = `ADDR_UPPER_STD,
  parameter logic [6:0] FIXED_ADDR = `FIXED_ADDR_STD
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic addr_select_pin0_in,
  input wire logic addr_select_pin1_in,
  input wire logic addr_select_pin2_in,
  output logic sda_out,
  output logic sda_oe_n_out,
  output logic [`CODE_W-1:0] dac_code_out,
  output logic power_down_out,
  output logic internal_ref_out
);

  generate
    if (ADDR_UPPER != `ADDR_UPPER_STD && ADDR_UPPER != `ADDR_UPPER_ALT) begin : g_bad_upper
      $error("ADDR_UPPER must be one of the two factory prefixes");
    end
    if (FIXED_ADDR != `FIXED_ADDR_STD && FIXED_ADDR != `FIXED_ADDR_ALT) begin : g_bad_fixed
      $error("FIXED_ADDR must be one of the two factory addresses");
    end
  endgenerate

  line_if ln();
  upd_if up();

  rx_regs_t q;
  rx_regs_t d;

  function automatic logic own_match(input logic [6:0] a, input logic [2:0] pins);
    if (PINLESS) begin
      own_match = (a == FIXED_ADDR);
    end else begin
      own_match = (a == {ADDR_UPPER, pins});
    end
  endfunction

  line_sampler u_sampler (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .pins_in({addr_select_pin2_in, addr_select_pin1_in, addr_select_pin0_in, sda_in, scl_in}),
    .ln(ln)
  );

  always_comb begin
    d = q;
    d.load = 1'b0;
    d.pd_load = 1'b0;
    d.clear = 1'b0;
    if (ln.stop) begin
      // A STOP ends any transfer; only an addressed device updates
      if (q.addressed) begin
        d.pd_load = 1'b1;
        if (!q.ctrl_in[`CMD_SYNC_BIT]) begin
          d.load = 1'b1;
        end
      end
      d.st = ST_IDLE;
      d.cnt = `BIT_ZERO;
      d.ack = 1'b0;
      d.sda_oe_n = 1'b1;
      d.addressed = 1'b0;
      d.sync_hit = 1'b0;
    end else if (ln.start) begin
      // Partial bytes die here; committed registers stay
      d.st = ST_ADDR;
      d.cnt = `BIT_ZERO;
      d.ack = 1'b0;
      d.sda_oe_n = 1'b1;
      d.sync_hit = 1'b0;
    end else if (q.st != ST_IDLE) begin
      if (ln.scl_rise) begin
        if (q.st != ST_IGNORE && q.cnt < `BYTE_BITS) begin
          d.sh = {q.sh[6:0], ln.sda};
          d.cnt = q.cnt + 4'h1;
        end else if (q.cnt == `BYTE_BITS) begin
          d.cnt = `BIT_ZERO;
          if (q.ack) begin
            case (q.st)
              ST_ADDR: begin
                if (q.sync_hit) begin
                  // Acts on the rising edge of the SYNC acknowledge
                  if (q.sh[0]) begin
                    if (q.ctrl_in[`CMD_SYNC_BIT]) begin
                      d.load = 1'b1;
                    end
                  end else begin
                    d.clear = 1'b1;
                    d.ctrl_in = `CTRL_RESET;
                    d.low_tmp = `BYTE_RESET;
                    d.code_in = `CODE_RESET;
                  end
                  d.st = ST_IGNORE;
                end else begin
                  d.st = ST_CMD;
                  d.addressed = 1'b1;
                end
              end
              ST_CMD: begin
                // Upper command bits are don't care
                d.ctrl_in = q.sh[`CTRL_W-1:0];
                d.st = ST_LOW;
              end
              ST_LOW: begin
                d.low_tmp = q.sh;
                d.st = ST_HIGH;
              end
              ST_HIGH: begin
                // Both data bytes commit together at the last acknowledge
                d.code_in = {q.sh[1:0], q.low_tmp};
                d.st = ST_IGNORE;
              end
              default: begin
                d.st = ST_IGNORE;
              end
            endcase
          end
        end
      end else if (ln.scl_fall) begin
        if (q.ack && q.cnt == `BIT_ZERO) begin
          d.ack = 1'b0;
          d.sda_oe_n = 1'b1;
        end else if (q.st != ST_IGNORE && q.cnt == `BYTE_BITS && !q.ack) begin
          // The master has released SDA for the ninth pulse
          case (q.st)
            ST_ADDR: begin
              if (own_match(q.sh[7:1], ln.addr_pins) && !q.sh[0]) begin
                d.ack = 1'b1;
                d.sda_oe_n = 1'b0;
              end else if (q.sh[7:1] == `SYNC_ADDR) begin
                d.ack = 1'b1;
                d.sda_oe_n = 1'b0;
                d.sync_hit = 1'b1;
              end else begin
                d.st = ST_IGNORE;
              end
            end
            default: begin
              d.ack = 1'b1;
              d.sda_oe_n = 1'b0;
            end
          endcase
        end
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      q <= '{st: ST_IDLE, cnt: `BIT_ZERO, sh: `BYTE_RESET, ack: 1'b0, sync_hit: 1'b0,
             addressed: 1'b0, ctrl_in: `CTRL_RESET, low_tmp: `BYTE_RESET,
             code_in: `CODE_RESET, sda_oe_n: 1'b1, sda_lvl: 1'b0, load: 1'b0,
             pd_load: 1'b0, clear: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign up.load = q.load;
  assign up.pd_load = q.pd_load;
  assign up.clear = q.clear;
  assign up.code = q.code_in;
  assign up.ctrl = q.ctrl_in;

  // The pin only ever pulls low; the enable decides when
  assign sda_out = q.sda_lvl;
  assign sda_oe_n_out = q.sda_oe_n;

  dac_output_latch u_latch (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .up(up),
    .code_out(dac_code_out),
    .pd_out(power_down_out),
    .iref_out(internal_ref_out)
  );

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);

  a_start_to_addr: assert property (
    ln.start && !ln.stop |=> q.st == ST_ADDR && q.cnt == 4'h0 && sda_oe_n_out)
    else $error("START did not restart address reception");

  a_stop_to_idle: assert property (
    ln.stop |=> q.st == ST_IDLE && sda_oe_n_out && !q.addressed)
    else $error("STOP did not return receiver to idle");

  a_only_pull_low: assert property (
    !sda_oe_n_out |-> !sda_out && q.ack && q.cnt inside {4'h8, 4'h0})
    else $error("SDA driven outside an acknowledge");

  a_ack_held_high: assert property (
    q.ack && ln.scl && !ln.stop && !ln.start |=> !sda_oe_n_out || ln.scl_fall)
    else $error("Acknowledge released while SCL high");

  a_foreign_no_ack: assert property (
    q.st == ST_ADDR && q.cnt == 4'h8 && ln.scl_fall && !ln.start && !ln.stop && !q.ack
    && !(own_match(q.sh[7:1], ln.addr_pins) && !q.sh[0]) && q.sh[7:1] != `SYNC_ADDR
    |=> sda_oe_n_out && q.st == ST_IGNORE)
    else $error("Foreign address acknowledged");

  a_read_no_ack: assert property (
    q.st == ST_ADDR && q.cnt == 4'h8 && ln.scl_fall && !ln.start && !ln.stop
    && own_match(q.sh[7:1], ln.addr_pins) && q.sh[0] |=> sda_oe_n_out)
    else $error("Read to own address acknowledged");

  a_cmd_latched: assert property (
    q.st == ST_CMD && q.ack && q.cnt == 4'h8 && ln.scl_rise && !ln.start && !ln.stop
    |=> q.ctrl_in == $past(q.sh[2:0]) && q.st == ST_LOW)
    else $error("Command byte not latched at its acknowledge");

  a_code_assembled: assert property (
    q.st == ST_HIGH && q.ack && q.cnt == 4'h8 && ln.scl_rise && !ln.start && !ln.stop
    |=> q.code_in == {$past(q.sh[1:0]), $past(q.low_tmp)})
    else $error("Data code assembled wrongly");

  a_interrupt_keeps: assert property (
    (q.st == ST_LOW || q.st == ST_HIGH) && (ln.start || ln.stop)
    |=> $stable(q.code_in) && $stable(q.ctrl_in))
    else $error("Interrupted transfer changed registers");

  a_stop_update: assert property (
    ln.stop && q.addressed && !q.ctrl_in[`CMD_SYNC_BIT]
    |-> ##2 dac_code_out == $past(q.code_in, 2) && power_down_out == $past(q.ctrl_in[1], 2))
    else $error("STOP did not update outputs");

  a_sync_holds_stop: assert property (
    ln.stop && q.ctrl_in[`CMD_SYNC_BIT] |-> ##2 $stable(dac_code_out))
    else $error("Output updated at STOP in sync mode");

  a_sync_clear: assert property (
    q.sync_hit && q.ack && q.cnt == 4'h8 && ln.scl_rise && !q.sh[0] && !ln.start && !ln.stop
    |-> ##2 dac_code_out == 10'h000 && !power_down_out && !internal_ref_out)
    else $error("SYNC clear did not clear the latches");

  a_bit_shifted: assert property (
    q.st != ST_IDLE && q.st != ST_IGNORE && q.cnt < 4'h8 && ln.scl_rise
    && !ln.start && !ln.stop |=> q.sh == {$past(q.sh[6:0]), $past(ln.sda)})
    else $error("Data bit not taken on rising SCL");

  a_shift_on_rise: assert property (
    !ln.scl_rise && !ln.start && !ln.stop |=> $stable(q.sh) && $stable(q.cnt))
    else $error("Shift register moved without a rising SCL");

  a_own_addr_ack: assert property (
    !PINLESS && q.st == ST_ADDR && q.cnt == 4'h8 && !q.ack && ln.scl_fall
    && !ln.start && !ln.stop && q.sh == {ADDR_UPPER, ln.addr_pins, 1'b0}
    |=> !sda_oe_n_out && q.ack && !q.sync_hit)
    else $error("Own write address not acknowledged");

  a_sync_addr_ack: assert property (
    q.st == ST_ADDR && q.cnt == 4'h8 && !q.ack && ln.scl_fall && !ln.start && !ln.stop
    && q.sh[7:1] == `SYNC_ADDR |=> !sda_oe_n_out && q.sync_hit)
    else $error("SYNC address not acknowledged");

  a_low_latched: assert property (
    q.st == ST_LOW && q.ack && q.cnt == 4'h8 && ln.scl_rise && !ln.start && !ln.stop
    |=> q.low_tmp == $past(q.sh) && q.st == ST_HIGH)
    else $error("Low data byte not held at its acknowledge");

  a_code_commit: assert property (
    $changed(q.code_in) |-> $past(q.st) == ST_HIGH || q.clear)
    else $error("Data code changed outside the last acknowledge");

  a_ctrl_commit: assert property (
    $changed(q.ctrl_in) |-> $past(q.st) == ST_CMD || q.clear)
    else $error("Command changed outside its acknowledge");

  a_sync_update: assert property (
    q.sync_hit && q.ack && q.cnt == 4'h8 && ln.scl_rise && q.sh[0] && !ln.start && !ln.stop
    && q.ctrl_in[`CMD_SYNC_BIT] |-> ##2 dac_code_out == $past(q.code_in, 2)
    && internal_ref_out == $past(q.ctrl_in[`CMD_REF_BIT], 2))
    else $error("SYNC update did not load the outputs");

  a_sync_needs_select: assert property (
    q.sync_hit && q.ack && q.cnt == 4'h8 && ln.scl_rise && q.sh[0] && !ln.start && !ln.stop
    && !q.ctrl_in[`CMD_SYNC_BIT]
    |-> ##2 $stable(dac_code_out) && $stable(internal_ref_out))
    else $error("SYNC update taken without sync select");

  a_pd_at_stop: assert property (
    ln.stop && q.addressed |-> ##2 power_down_out == $past(q.ctrl_in[`CMD_PD_BIT], 2))
    else $error("Power-down select not applied at STOP");

  a_ref_follows: assert property (
    q.load && !q.clear |=> internal_ref_out == $past(q.ctrl_in[`CMD_REF_BIT]))
    else $error("Reference select not loaded with the code");

  a_chain_keeps: assert property (
    ln.start && !ln.stop && q.addressed |=> q.addressed)
    else $error("Repeated START dropped the pending update");

  a_idle_quiet: assert property (
    q.st == ST_IDLE |-> sda_oe_n_out && !q.ack)
    else $error("SDA pulled while idle");

  a_ignore_quiet: assert property (
    q.st == ST_IGNORE && !q.ack |=> sda_oe_n_out)
    else $error("Ignored transfer acknowledged");

  c_write_word: cover property (
    q.st == ST_HIGH && q.ack && q.cnt == 4'h8 && ln.scl_rise);
  c_sync_update: cover property (
    q.sync_hit && q.ack && q.cnt == 4'h8 && ln.scl_rise && q.sh[0] && q.ctrl_in[0]);
  c_sync_clear: cover property (q.clear);
  c_send_byte_stop: cover property (q.st == ST_LOW && ln.stop && q.addressed);
  c_chain_start: cover property (ln.start && q.addressed && q.st == ST_IGNORE);

endmodule

// *** dac_link_defines.svh ***
/*
  Constants of the two-wire DAC receiver: addresses, command byte fields,
  widths and reset values.
  Assumes it is included by bare name from the package and the modules.
*/
`ifndef DAC_LINK_DEFINES_SVH
`define DAC_LINK_DEFINES_SVH

`define SYNC_ADDR 7'h7e
`define ADDR_UPPER_STD 4'h4
`define ADDR_UPPER_ALT 4'h3
`define FIXED_ADDR_STD 7'h20
`define FIXED_ADDR_ALT 7'h21

`define CMD_SYNC_BIT 0
`define CMD_PD_BIT 1
`define CMD_REF_BIT 2
`define CTRL_W 3
`define CODE_W 10
`define LOW_W 8
`define BYTE_BITS 4'h8
`define BIT_ZERO 4'h0

`define CTRL_RESET 3'h0
`define CODE_RESET 10'h000
`define BYTE_RESET 8'h00

`define PIN_W 5
`define PIN_RESET 5'h03
`define PREV_RESET 2'h3

`endif

// *** dac_link_pkg.sv ***
/*
  Types of the two-wire DAC receiver: receiver states and the state records
  of each module.
  Assumes dac_link_defines.svh is on the include path.
*/
`include "dac_link_defines.svh"

package dac_link_pkg;

  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_CMD, ST_LOW, ST_HIGH, ST_IGNORE} rx_state_t;

  typedef struct packed {
    rx_state_t st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic ack;
    logic sync_hit;
    logic addressed;
    logic [`CTRL_W-1:0] ctrl_in;
    logic [`LOW_W-1:0] low_tmp;
    logic [`CODE_W-1:0] code_in;
    logic sda_oe_n;
    logic sda_lvl;
    logic load;
    logic pd_load;
    logic clear;
  } rx_regs_t;

  typedef struct packed {
    logic [`PIN_W-1:0] s1;
    logic [`PIN_W-1:0] s2;
    logic [1:0] prev;
  } sampler_regs_t;

  typedef struct packed {
    logic [`CODE_W-1:0] code;
    logic pd;
    logic iref;
  } latch_regs_t;

endpackage

// *** dac_link_if.sv ***
/*
  Interfaces between the receiver modules: sampled line events, and the
  update requests toward the output latch.
  Assumes the package is compiled first.
*/
`timescale 1ns/1ps
`include "dac_link_defines.svh"

interface line_if;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  logic [2:0] addr_pins;
  modport src(output scl, sda, scl_rise, scl_fall, start, stop, addr_pins);
  modport dst(input scl, sda, scl_rise, scl_fall, start, stop, addr_pins);
endinterface

interface upd_if;
  logic load;
  logic pd_load;
  logic clear;
  logic [`CODE_W-1:0] code;
  logic [`CTRL_W-1:0] ctrl;
  modport src(output load, pd_load, clear, code, ctrl);
  modport dst(input load, pd_load, clear, code, ctrl);
endinterface

// *** line_sampler.sv ***
/*
  Two-flop synchroniser for the bus and strap pins, with clock edge and
  START/STOP detection on the synchronised levels.
  Assumes pins are asynchronous to clk_in and the bus clock is far slower.
*/
`timescale 1ns/1ps
`include "dac_link_defines.svh"

module line_sampler
  import dac_link_pkg::*;
(
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic [`PIN_W-1:0] pins_in,
  line_if.src ln
);

  sampler_regs_t q;
  sampler_regs_t d;

  // Pin order: {sel2, sel1, sel0, sda, scl}
  always_comb begin
    d = q;
    d.s1 = pins_in;
    d.s2 = q.s1;
    d.prev = q.s2[1:0];
  end

  // Lines rest released high while idle
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      q <= '{s1: `PIN_RESET, s2: `PIN_RESET, prev: `PREV_RESET};
    end else begin
      q <= d;
    end
  end

  assign ln.scl = q.s2[0];
  assign ln.sda = q.s2[1];
  assign ln.scl_rise = q.s2[0] & ~q.prev[0];
  assign ln.scl_fall = ~q.s2[0] & q.prev[0];
  assign ln.start = q.s2[0] & q.prev[0] & q.prev[1] & ~q.s2[1];
  assign ln.stop = q.s2[0] & q.prev[0] & ~q.prev[1] & q.s2[1];
  assign ln.addr_pins = q.s2[4:2];

endmodule

// *** dac_output_latch.sv ***
/*
  Output latches of the converter: code, reference choice and power-down.
  Assumes one-cycle load, power-down load and clear requests from the
  receiver; clear has priority.
*/
`timescale 1ns/1ps
`include "dac_link_defines.svh"

module dac_output_latch
  import dac_link_pkg::*;
(
  input wire logic clk_in,
  input wire logic sys_rst_in,
  upd_if.dst up,
  output logic [`CODE_W-1:0] code_out,
  output logic pd_out,
  output logic iref_out
);

  latch_regs_t q;
  latch_regs_t d;

  always_comb begin
    d = q;
    if (up.clear) begin
      d = '{code: `CODE_RESET, pd: 1'b0, iref: 1'b0};
    end else begin
      if (up.load) begin
        d.code = up.code;
        d.iref = up.ctrl[`CMD_REF_BIT];
      end
      if (up.pd_load) begin
        d.pd = up.ctrl[`CMD_PD_BIT];
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      q <= '{code: `CODE_RESET, pd: 1'b0, iref: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign code_out = q.code;
  assign pd_out = q.pd;
  assign iref_out = q.iref;

endmodule

// *** two_wire_master_model.sv ***
/*
  Behavioural two-wire bus master: START, STOP, byte and partial byte
  transfers with acknowledge sampling. SCL period 200 ns.
  Assumes the bench resolves SDA as a wired-AND with a pull-up.
*/
`timescale 1ns/1ps

module two_wire_master_model (
  output logic scl_out,
  output logic sda_n_out,
  input wire logic sda_in
);
  // Bus idles released high, SCL stands still between frames
  initial begin
    scl_out = 1'b1;
    sda_n_out = 1'b1;
  end

  // Handles both a first START and a repeated START from mid-frame
  task automatic start();
    if (scl_out === 1'b0) begin
      sda_n_out = 1'b1;
      #50;
      scl_out = 1'b1;
      #100;
    end else begin
      #100;
    end
    sda_n_out = 1'b0;
    #100;
    scl_out = 1'b0;
    #50;
  endtask

  task automatic stop();
    sda_n_out = 1'b0;
    #50;
    scl_out = 1'b1;
    #100;
    sda_n_out = 1'b1;
    #100;
  endtask

  // Sends n bits MSB first; the ninth pulse only for a whole byte
  task automatic put(input int n, input logic [7:0] b, output logic ack);
    logic s1;
    ack = 1'b0;
    for (int i = 0; i < n; i++) begin
      sda_n_out = b[7 - i];
      #50;
      scl_out = 1'b1;
      #100;
      scl_out = 1'b0;
      #50;
    end
    if (n == 8) begin
      sda_n_out = 1'b1;
      #50;
      scl_out = 1'b1;
      #25;
      s1 = sda_in;
      #50;
      ack = (s1 === 1'b0) && (sda_in === 1'b0);
      #25;
      scl_out = 1'b0;
      #50;
    end
  endtask
endmodule

// *** dac_two_wire_write_slave_tb.sv ***
/*
  Self-checking bench of the two-wire DAC receiver: frames from the master
  model, outputs compared against values worked out from the command layout.
  Assumes the design, package, header and master model are compiled first.
*/
`timescale 1ns/1ps

module dac_two_wire_write_slave_tb;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [2:0] pins = 3'b101;
  logic scl;
  logic m_sda_n;
  wire logic bus_sda;
  logic sda_out;
  logic sda_oe_n_out;
  logic [9:0] dac_code;
  logic pd;
  logic iref;
  logic ack;
  int fails = 0;
  int checks_done = 0;
  int cyc = 0;

  // Wired-AND with pull-up; device pulls low when its enable is low
  assign bus_sda = m_sda_n & (sda_oe_n_out | sda_out);

  dac_two_wire_write_slave u_dac_two_wire_write_slave (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .scl_in(scl),
    .sda_in(bus_sda),
    .addr_select_pin0_in(pins[0]),
    .addr_select_pin1_in(pins[1]),
    .addr_select_pin2_in(pins[2]),
    .sda_out(sda_out),
    .sda_oe_n_out(sda_oe_n_out),
    .dac_code_out(dac_code),
    .power_down_out(pd),
    .internal_ref_out(iref)
  );

  two_wire_master_model u_m (
    .scl_out(scl),
    .sda_n_out(m_sda_n),
    .sda_in(bus_sda)
  );

  initial begin
    forever #12.5 clk_in = ~clk_in;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      summarize();
    end
  end

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic outs(input logic [9:0] c, input logic p, input logic r);
    repeat (10) @(negedge clk_in);
    check("dac_code", {6'h00, c}, {6'h00, dac_code});
    check("power_down", {15'h0000, p}, {15'h0000, pd});
    check("internal_ref", {15'h0000, r}, {15'h0000, iref});
  endtask

  // Address byte, then n bytes of d from the top; STOP if fin
  task automatic frame(input logic [6:0] a, input logic rw, input logic exp_a, input int n,
                       input logic [23:0] d, input logic fin);
    logic k;
    u_m.start();
    u_m.put(8, {a, rw}, k);
    check("addr_ack", {15'h0000, exp_a}, {15'h0000, k});
    for (int i = 0; i < n; i++) begin
      u_m.put(8, d[23 - 8 * i -: 8], k);
      check("byte_ack", {15'h0000, exp_a}, {15'h0000, k});
    end
    if (fin) begin
      u_m.stop();
    end
  endtask

  initial begin
    repeat (3) @(negedge clk_in);
    sys_rst_in = 1'b0;
    repeat (8) @(negedge clk_in);
    outs(10'h000, 1'b0, 1'b0);
    check("sda_oe_n", 16'h0001, {15'h0000, sda_oe_n_out});
    check("sda_out", 16'h0000, {15'h0000, sda_out});
    frame(7'h25, 1'b0, 1'b1, 3, 24'hf85afe, 1'b0);
    outs(10'h000, 1'b0, 1'b0);
    frame(7'h7e, 1'b1, 1'b1, 0, 24'h000000, 1'b0);
    outs(10'h000, 1'b0, 1'b0);
    u_m.stop();
    outs(10'h25a, 1'b0, 1'b0);
    check("sda_oe_n", 16'h0001, {15'h0000, sda_oe_n_out});
    frame(7'h25, 1'b0, 1'b1, 3, 24'h040103, 1'b1);
    outs(10'h301, 1'b0, 1'b1);
    frame(7'h25, 1'b0, 1'b1, 1, 24'h000000, 1'b1);
    outs(10'h301, 1'b0, 1'b0);
    frame(7'h25, 1'b0, 1'b1, 2, 24'h041100, 1'b1);
    outs(10'h301, 1'b0, 1'b1);
    frame(7'h25, 1'b0, 1'b1, 0, 24'h000000, 1'b0);
    u_m.put(4, 8'hf0, ack);
    u_m.stop();
    outs(10'h301, 1'b0, 1'b1);
    frame(7'h26, 1'b0, 1'b0, 3, 24'h003c00, 1'b1);
    outs(10'h301, 1'b0, 1'b1);
    frame(7'h25, 1'b1, 1'b0, 0, 24'h000000, 1'b1);
    frame(7'h25, 1'b0, 1'b1, 3, 24'h01ff00, 1'b1);
    outs(10'h301, 1'b0, 1'b1);
    frame(7'h7e, 1'b1, 1'b1, 0, 24'h000000, 1'b0);
    outs(10'h0ff, 1'b0, 1'b0);
    u_m.stop();
    frame(7'h25, 1'b0, 1'b1, 1, 24'h030000, 1'b1);
    outs(10'h0ff, 1'b1, 1'b0);
    frame(7'h7e, 1'b0, 1'b1, 0, 24'h000000, 1'b1);
    outs(10'h000, 1'b0, 1'b0);
    pins = 3'b010;
    repeat (8) @(negedge clk_in);
    frame(7'h22, 1'b0, 1'b1, 3, 24'h00ff03, 1'b0);
    frame(7'h25, 1'b0, 1'b0, 0, 24'h000000, 1'b0);
    outs(10'h000, 1'b0, 1'b0);
    u_m.stop();
    outs(10'h3ff, 1'b0, 1'b0);
    summarize();
  end
endmodule
